// File: logic/ofe_regs_map.vh
/*
 * Register map, field positions, reset values and divider codes for the
 * optical front-end result and clock register bank.
 * Assumes it is included by the register bank module only, by bare name.
 */
`ifndef OFE_REGS_MAP_VH
`define OFE_REGS_MAP_VH

`define OFE_REG_AMB1        8'h2D
`define OFE_REG_NET2        8'h2E
`define OFE_REG_NET1        8'h2F
`define OFE_REG_CFG         8'h31
`define OFE_REG_SLP_ST      8'h32
`define OFE_REG_SLP_END     8'h33

`define OFE_CFG_DETACH_BIT  10
`define OFE_CFG_SHORT_BIT   5
`define OFE_CFG_DIV_MSB     2
`define OFE_CFG_DIV_LSB     0
`define OFE_CNT_MSB         15

`define OFE_RESULT_RST      24'h000000
`define OFE_CNT_RST         16'h0000
`define OFE_DIV_RST         3'h0
`define OFE_ZERO24          24'h000000
`define OFE_ZERO13          13'h0000
`define OFE_ZERO8           8'h00
`define OFE_ZERO2           2'h0

`define OFE_DIV_CODE_BY2    3'h0
`define OFE_DIV_CODE_BY8    3'h1
`define OFE_DIV_CODE_BY12   3'h3
`define OFE_DIV_CODE_BY4    3'h4
`define OFE_DIV_CODE_BY1    3'h5
`define OFE_DIV_CODE_BY6    3'h6
`define OFE_RATIO_NONE      4'h0
`define OFE_RATIO_1         4'h1
`define OFE_RATIO_2         4'h2
`define OFE_RATIO_4         4'h4
`define OFE_RATIO_6         4'h6
`define OFE_RATIO_8         4'h8
`define OFE_RATIO_12        4'hC

`define OFE_BITS_PER_BYTE   4'h8
`define OFE_LAST_TX_BIT     4'h7
`define OFE_LAST_BYTE       2'h2
`define OFE_DEV_ADDR_DEF    7'h58

`endif

// File: logic/ofe_result_clock_regs.v
/*
 * Result and clock configuration register bank of the optical front-end,
 * reached over the two-wire serial port (7-bit device address, register
 * pointer byte, 24-bit words sent as three bytes, most significant first).
 * Assumes scl_in/sda_in are already synchronous to mclk and that the pad
 * logic resolves sda from sda_oe (drive low when high).
 */
`timescale 1ns/10ps
`include "ofe_regs_map.vh"

module ofe_result_clock_regs #(
    parameter [6:0] DEV_ADDR = `OFE_DEV_ADDR_DEF
) (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    input  wire        result_load,
    input  wire [23:0] ambient_one_code,
    input  wire [23:0] second_led_net_code,
    input  wire [23:0] first_led_net_code,
    input  wire        transimpedance_amplifier_down,
    input  wire [15:0] timing_count,
    output reg         photodiode_detach,
    output reg         photodiode_bias_en,
    output reg         inputs_to_common_mode,
    output reg         divided_clock_tick,
    output reg         sleep_interval_active
);

    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_ADDR  = 7'h02;
    localparam [6:0] ST_REG   = 7'h04;
    localparam [6:0] ST_WDATA = 7'h08;
    localparam [6:0] ST_ACK   = 7'h10;
    localparam [6:0] ST_RDATA = 7'h20;
    localparam [6:0] ST_MACK  = 7'h40;

    reg  [23:0] amb1_q;
    reg  [23:0] net2_q;
    reg  [23:0] net1_q;
    reg         detach_q;
    reg         short_en_q;
    reg  [2:0]  div_sel_q;
    reg  [15:0] slp_start_q;
    reg  [15:0] slp_end_q;

    reg  [6:0]  state;
    reg  [6:0]  ack_next;
    reg         scl_q;
    reg         sda_q;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shreg;
    reg  [1:0]  byte_idx;
    reg  [7:0]  reg_ptr;
    reg  [15:0] wr_word;
    reg  [23:0] rd_hold;
    reg  [3:0]  div_cnt;

    wire        scl_rise   = scl_in & ~scl_q;
    wire        scl_fall   = ~scl_in & scl_q;
    wire        start_seen = scl_in & scl_q & sda_q & ~sda_in;
    wire        stop_seen  = scl_in & scl_q & ~sda_q & sda_in;
    wire [23:0] wr_full    = {wr_word, shreg};
    wire [23:0] rd_cur     = (byte_idx == `OFE_ZERO2) ? rd_word(reg_ptr) : rd_hold;
    wire [7:0]  rd_byte    = pick_byte(rd_cur, byte_idx);
    wire [3:0]  div_ratio  = ratio_of(div_sel_q);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // detach bit is write-only and so reads back as zero
    function [23:0] rd_word;
        input [7:0] ptr;
        begin
            case (ptr)
                `OFE_REG_AMB1:    rd_word = amb1_q;
                `OFE_REG_NET2:    rd_word = net2_q;
                `OFE_REG_NET1:    rd_word = net1_q;
                `OFE_REG_CFG:     rd_word = {`OFE_ZERO13, 1'b0, 4'h0, short_en_q,
                                             `OFE_ZERO2, div_sel_q};
                `OFE_REG_SLP_ST:  rd_word = {`OFE_ZERO8, slp_start_q};
                `OFE_REG_SLP_END: rd_word = {`OFE_ZERO8, slp_end_q};
                default:          rd_word = `OFE_ZERO24;
            endcase
        end
    endfunction

    function [7:0] pick_byte;
        input [23:0] word;
        input [1:0]  idx;
        begin
            case (idx)
                2'h0:    pick_byte = word[23:16];
                2'h1:    pick_byte = word[15:8];
                default: pick_byte = word[7:0];
            endcase
        end
    endfunction

    // forbidden codes give ratio zero: the tick stops rather than guess
    function [3:0] ratio_of;
        input [2:0] sel;
        begin
            case (sel)
                `OFE_DIV_CODE_BY2:  ratio_of = `OFE_RATIO_2;
                `OFE_DIV_CODE_BY8:  ratio_of = `OFE_RATIO_8;
                `OFE_DIV_CODE_BY12: ratio_of = `OFE_RATIO_12;
                `OFE_DIV_CODE_BY4:  ratio_of = `OFE_RATIO_4;
                `OFE_DIV_CODE_BY1:  ratio_of = `OFE_RATIO_1;
                `OFE_DIV_CODE_BY6:  ratio_of = `OFE_RATIO_6;
                default:            ratio_of = `OFE_RATIO_NONE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // conversion results, loaded by the conversion engine

    always @(posedge mclk) begin
        if (!resetn) begin
            amb1_q <= `OFE_RESULT_RST;
            net2_q <= `OFE_RESULT_RST;
            net1_q <= `OFE_RESULT_RST;
        end else if (result_load) begin
            amb1_q <= ambient_one_code;
            net2_q <= second_led_net_code;
            net1_q <= first_led_net_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial port and writable registers

    always @(posedge mclk) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            state       <= ST_IDLE;
            ack_next    <= ST_IDLE;
            bit_cnt     <= 4'h0;
            shreg       <= `OFE_ZERO8;
            byte_idx    <= `OFE_ZERO2;
            reg_ptr     <= `OFE_ZERO8;
            wr_word     <= `OFE_CNT_RST;
            rd_hold     <= `OFE_ZERO24;
            sda_out     <= 1'b0;
            sda_oe      <= 1'b0;
            detach_q    <= 1'b0;
            short_en_q  <= 1'b0;
            div_sel_q   <= `OFE_DIV_RST;
            slp_start_q <= `OFE_CNT_RST;
            slp_end_q   <= `OFE_CNT_RST;
        end else if (start_seen) begin
            state   <= ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (stop_seen) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            case (state)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        shreg   <= {shreg[6:0], sda_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `OFE_BITS_PER_BYTE) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_ADDR) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                sda_oe   <= 1'b1;
                                state    <= ST_ACK;
                                ack_next <= shreg[0] ? ST_RDATA : ST_REG;
                                byte_idx <= `OFE_ZERO2;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end else if (state == ST_REG) begin
                            reg_ptr  <= shreg;
                            byte_idx <= `OFE_ZERO2;
                            sda_oe   <= 1'b1;
                            state    <= ST_ACK;
                            ack_next <= ST_WDATA;
                        end else begin
                            sda_oe   <= 1'b1;
                            state    <= ST_ACK;
                            ack_next <= ST_WDATA;
                            wr_word  <= wr_full[15:0];
                            if (byte_idx == `OFE_LAST_BYTE) begin
                                byte_idx <= `OFE_ZERO2;
                                reg_ptr  <= reg_ptr + 8'h01;
                                // reserved positions are simply not stored
                                case (reg_ptr)
                                    `OFE_REG_CFG: begin
                                        detach_q   <= wr_full[`OFE_CFG_DETACH_BIT];
                                        short_en_q <= wr_full[`OFE_CFG_SHORT_BIT];
                                        div_sel_q  <= wr_full[`OFE_CFG_DIV_MSB:
                                                              `OFE_CFG_DIV_LSB];
                                    end
                                    `OFE_REG_SLP_ST:
                                        slp_start_q <= wr_full[`OFE_CNT_MSB:0];
                                    `OFE_REG_SLP_END:
                                        slp_end_q <= wr_full[`OFE_CNT_MSB:0];
                                    default: ;
                                endcase
                            end else begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        state   <= ack_next;
                        if (ack_next == ST_RDATA) begin
                            if (byte_idx == `OFE_ZERO2)
                                rd_hold <= rd_cur; // whole word snapshot, no tearing
                            sda_oe <= ~rd_byte[7];
                            shreg  <= {rd_byte[6:0], 1'b0};
                        end else begin
                            sda_oe <= 1'b0;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_cnt == `OFE_LAST_TX_BIT) begin
                            sda_oe <= 1'b0;
                            state  <= ST_MACK;
                            if (byte_idx == `OFE_LAST_BYTE) begin
                                byte_idx <= `OFE_ZERO2;
                                reg_ptr  <= reg_ptr + 8'h01;
                            end else begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end else begin
                            sda_oe  <= ~shreg[7];
                            shreg   <= {shreg[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        state    <= sda_in ? ST_IDLE : ST_ACK;
                        ack_next <= ST_RDATA;
                    end
                end
                ST_IDLE: ;
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog control levels, divider tick and sleep window

    always @(posedge mclk) begin
        if (!resetn) begin
            photodiode_detach     <= 1'b0;
            photodiode_bias_en    <= 1'b1;
            inputs_to_common_mode <= 1'b0;
        end else begin
            photodiode_detach     <= detach_q;
            photodiode_bias_en    <= ~detach_q;
            inputs_to_common_mode <= short_en_q & transimpedance_amplifier_down;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            div_cnt            <= 4'h0;
            divided_clock_tick <= 1'b0;
        end else if (div_ratio == `OFE_RATIO_NONE) begin
            div_cnt            <= 4'h0;
            divided_clock_tick <= 1'b0;
        end else if (div_cnt >= div_ratio - 4'h1) begin
            div_cnt            <= 4'h0;
            divided_clock_tick <= 1'b1;
        end else begin
            div_cnt            <= div_cnt + 4'h1;
            divided_clock_tick <= 1'b0;
        end
    end

    // start wins when start and end counts are equal
    always @(posedge mclk) begin
        if (!resetn)
            sleep_interval_active <= 1'b0;
        else if (timing_count == slp_start_q)
            sleep_interval_active <= 1'b1;
        else if (timing_count == slp_end_q)
            sleep_interval_active <= 1'b0;
    end

endmodule // ofe_result_clock_regs

// File: testbench/ofe_regs_asserts.sv
/* checker: port-level properties of the result and clock register bank.
   assumes one clock, mclk, and synchronous active-low resetn. */
`timescale 1ns/10ps
module ofe_regs_chk (
    input wire mclk,
    input wire resetn,
    input wire scl_in,
    input wire sda_oe,
    input wire transimpedance_amplifier_down,
    input wire photodiode_detach,
    input wire photodiode_bias_en,
    input wire inputs_to_common_mode,
    input wire divided_clock_tick
);
default clocking cb @(posedge mclk); endclocking
default disable iff (!resetn);
////////////////////////////////////////////////////////////
sequence s_rel;
    !resetn ##1 resetn;
endsequence
property p_rst;
    disable iff (1'b0) s_rel |-> photodiode_bias_en && !photodiode_detach && !sda_oe;
endproperty
a_rst: assert property (p_rst) else $error("bad outputs after reset");
property p_bias;
    photodiode_bias_en == !photodiode_detach;
endproperty
a_bias: assert property (p_bias) else $error("bias on while detached");
// detach lags the word commit on a serial clock fall by one cycle
property p_det;
    $changed(photodiode_detach) |-> !$past(scl_in, 2) && $past(scl_in, 3);
endproperty
a_det: assert property (p_det) else $error("detach moved off a commit");
property p_cm;
    inputs_to_common_mode |-> $past(transimpedance_amplifier_down);
endproperty
a_cm: assert property (p_cm) else $error("inputs shorted while powered");
property p_cm0;
    $fell(transimpedance_amplifier_down) |=> !inputs_to_common_mode;
endproperty
a_cm0: assert property (p_cm0) else $error("short held after power-up");
// loose bound: a divider change may restart the count
property p_tick;
    divided_clock_tick |-> ##[1:32] divided_clock_tick;
endproperty
a_tick: assert property (p_tick) else $error("divided tick stopped");
property p_oe_rise;
    $rose(sda_oe) |-> !$past(scl_in) && $past(scl_in, 2);
endproperty
a_oe_rise: assert property (p_oe_rise) else $error("data pulled off a clock fall");
property p_oe_hold;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
endproperty
a_oe_hold: assert property (p_oe_hold) else $error("data moved with clock high");
endmodule // ofe_regs_chk
bind ofe_result_clock_regs ofe_regs_chk chk (.mclk, .resetn, .scl_in, .sda_oe,
    .transimpedance_amplifier_down, .photodiode_detach, .photodiode_bias_en,
    .inputs_to_common_mode, .divided_clock_tick);

// File: testbench/ofe_host_model.sv
/* host controller model: two-wire master, word writes and reads.
   assumes the bench resolves the data line as the AND of host and device drives. */
`timescale 1ns/10ps
module ofe_host_model #(
    parameter [6:0] ADDR = 7'h58
) (
    input  wire mclk,
    input  wire sda_line,
    output reg  scl,
    output reg  sda
);
integer hp;
integer nak;
initial begin
    scl = 1'b1;
    sda = 1'b1;
    hp = 4;
    nak = 0;
end
////////////////////////////////////////////////////////////
task hold;
    repeat (hp) @(negedge mclk);
endtask
task gap(input s, input c);
begin
    sda = s;
    hold;
    scl = c;
    hold;
end
endtask
// last bit is our ack/nack, or released to read the device ack
task bytex(input [7:0] d, input last, input chk, output [7:0] r);
    reg [8:0] sh;
    integer i;
begin
    sh = {d, last};
    for (i = 8; i >= 0; i = i - 1) begin
        gap(sh[i], 1'b1);
        sh[i] = sda_line;
        scl = 1'b0;
        hold;
    end
    r = sh[8:1];
    if (chk && sh[0])
        nak = nak + 1;
end
endtask
task start;
begin
    gap(1'b1, 1'b1);
    gap(1'b0, 1'b0);
end
endtask
task stop;
begin
    gap(1'b0, 1'b1);
    gap(1'b1, 1'b1);
end
endtask
task wr(input [7:0] p, input [23:0] w);
    reg [7:0] r;
begin
    start;
    bytex({ADDR, 1'b0}, 1'b1, 1'b1, r);
    bytex(p, 1'b1, 1'b1, r);
    bytex(w[23:16], 1'b1, 1'b1, r);
    bytex(w[15:8], 1'b1, 1'b1, r);
    bytex(w[7:0], 1'b1, 1'b1, r);
    stop;
end
endtask
task rd(input [7:0] p, output [23:0] w);
begin
    start;
    bytex({ADDR, 1'b0}, 1'b1, 1'b1, w[7:0]);
    bytex(p, 1'b1, 1'b1, w[7:0]);
    start;
    bytex({ADDR, 1'b1}, 1'b1, 1'b1, w[7:0]);
    bytex(8'hFF, 1'b0, 1'b0, w[23:16]);
    bytex(8'hFF, 1'b0, 1'b0, w[15:8]);
    bytex(8'hFF, 1'b1, 1'b0, w[7:0]);
    stop;
end
endtask
endmodule // ofe_host_model

// File: testbench/testbench.sv
/* self-checking bench for the register bank and its host model.
   assumes the checker is bound from its own file. */
`timescale 1ns/10ps
module testbench;
reg         mclk;
reg         resetn;
reg         result_load;
reg         amp_down;
reg  [23:0] amb;
reg  [23:0] net2;
reg  [23:0] net1;
reg  [15:0] timing_count;
reg  [23:0] w;
wire        scl;
wire        host_sda;
wire        sda_oe;
wire        detach;
wire        bias_en;
wire        short_cm;
wire        tick;
wire        sleep;
wire        sda_val;
wire        sda_line = sda_oe ? (host_sda & sda_val) : host_sda;
integer     n_fail;
integer     checked;
integer     i;
integer     n;
ofe_result_clock_regs dut (.mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_val), .sda_oe(sda_oe), .result_load(result_load), .ambient_one_code(amb),
    .second_led_net_code(net2), .first_led_net_code(net1),
    .transimpedance_amplifier_down(amp_down), .timing_count(timing_count),
    .photodiode_detach(detach), .photodiode_bias_en(bias_en),
    .inputs_to_common_mode(short_cm), .divided_clock_tick(tick),
    .sleep_interval_active(sleep));
ofe_host_model host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(host_sda));
////////////////////////////////////////////////////////////
task check(input [23:0] got, input [23:0] exp);
begin
    checked = checked + 1;
    if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
end
endtask
task report_and_stop;
begin
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
end
endtask
task t_reset;
begin
    check(bias_en, 1'b1);
    for (i = 8'h2D; i <= 8'h33; i = i + 1) begin
        host.rd(i[7:0], w);
        check(w, 24'h000000);
    end
end
endtask
task t_results;
begin
    amb = 24'h800001;
    net2 = 24'h7FFFFE;
    net1 = 24'hFFFFFF;
    result_load = 1'b1;
    @(negedge mclk);
    result_load = 1'b0;
    host.wr(8'h2D, 24'h000000);
    host.rd(8'h2D, w);
    check(w, 24'h800001);
    host.rd(8'h2E, w);
    check(w, 24'h7FFFFE);
    host.rd(8'h2F, w);
    check(w, 24'hFFFFFF);
end
endtask
task t_cfg;
begin
    host.wr(8'h31, 24'h000425);
    @(negedge mclk);
    check(detach, 1'b1);
    check(bias_en, 1'b0);
    host.rd(8'h31, w);
    check(w, 24'h000025);
    amp_down = 1'b1;
    repeat (2) @(negedge mclk);
    check(short_cm, 1'b1);
    amp_down = 1'b0;
    repeat (2) @(negedge mclk);
    check(short_cm, 1'b0);
end
endtask
// every legal code; 24 cycles hold a whole number of ticks at each ratio
task t_div;
    reg [3:0] nr [0:7];
begin
    nr = '{4'h2, 4'h8, 4'h0, 4'hC, 4'h4, 4'h1, 4'h6, 4'h0};
    for (i = 0; i < 7; i = i + 1) begin
        if (i != 2) begin
            host.wr(8'h31, i);
            repeat (30) @(negedge mclk);
            n = 0;
            repeat (24) begin
                @(negedge mclk);
                n = n + tick;
            end
            check(n, 24 / nr[i]);
        end
    end
end
endtask
task t_sleep;
begin
    host.wr(8'h32, 24'h000005);
    host.wr(8'h33, 24'h000009);
    host.rd(8'h32, w);
    check(w, 24'h000005);
    timing_count = 16'h0005;
    repeat (2) @(negedge mclk);
    check(sleep, 1'b1);
    timing_count = 16'h0009;
    repeat (2) @(negedge mclk);
    check(sleep, 1'b0);
end
endtask
initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
end
initial begin
    repeat (100000) @(posedge mclk);
    n_fail = n_fail + 1;
    report_and_stop;
end
initial begin
    n_fail = 0;
    checked = 0;
    resetn = 1'b0;
    result_load = 1'b0;
    amp_down = 1'b0;
    amb = 24'h000000;
    net2 = 24'h000000;
    net1 = 24'h000000;
    timing_count = 16'h0000;
    repeat (3) @(negedge mclk);
    resetn = 1'b1;
    t_reset;
    t_results;
    t_cfg;
    t_div;
    t_sleep;
    check(host.nak, 0);
    report_and_stop;
end
endmodule // testbench
